// [core/amss_regs.vh]
/*
 Constants for the asynchronous memory strobe sequencer.
 Assumes inclusion by the sequencer core only.
*/
`ifndef AMSS_REGS_VH
`define AMSS_REGS_VH
`define AMSS_CS_IDLE 4'hf
`define AMSS_WORD_ADDR_W 22
`define AMSS_BYTE_ADDR_W 2
`define AMSS_DATA_W 16
`define AMSS_SETUP_W 4
`define AMSS_STROBE_W 6
`define AMSS_HOLD_W 3
`define AMSS_TA_W 2
`define AMSS_CNT_W 6
`endif

// [core/amss_seq.v]
/*
 Asynchronous memory strobe sequencer: runs one read or write access to an
 external asynchronous memory with programmable phase lengths.
 Assumes timing settings stay stable while busy and the data bus
 is resolved outside from mem_data_bus_out, mem_data_bus_oe.
*/
`timescale 1ns/1ps
`include "amss_regs.vh"
module amss_seq #(
   parameter CS_N = 4
) (
   input wire clock,
   input wire rst_n,
   input wire req_valid,
   input wire req_write,
   input wire [1:0] req_cs,
   input wire [`AMSS_WORD_ADDR_W-1:0] req_word_addr,
   input wire [`AMSS_BYTE_ADDR_W-1:0] req_byte_addr,
   input wire [`AMSS_DATA_W-1:0] req_wdata,
   input wire strobe_select_mode,
   input wire [`AMSS_SETUP_W-1:0] read_setup_count,
   input wire [`AMSS_STROBE_W-1:0] read_strobe_count,
   input wire [`AMSS_HOLD_W-1:0] read_hold_count,
   input wire [`AMSS_SETUP_W-1:0] write_setup_count,
   input wire [`AMSS_STROBE_W-1:0] write_strobe_count,
   input wire [`AMSS_HOLD_W-1:0] write_hold_count,
   input wire [`AMSS_TA_W-1:0] turnaround_count,
   output reg req_ready,
   output reg rd_valid,
   output reg [`AMSS_DATA_W-1:0] rd_data,
   output reg [CS_N-1:0] mem_chip_select_n,
   output reg mem_read_strobe_n,
   output reg mem_write_strobe_n,
   output reg [`AMSS_WORD_ADDR_W-1:0] mem_word_addr,
   output reg [`AMSS_BYTE_ADDR_W-1:0] mem_byte_addr,
   input wire [`AMSS_DATA_W-1:0] mem_data_bus_in,
   output reg [`AMSS_DATA_W-1:0] mem_data_bus_out,
   output reg mem_data_bus_oe
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_SETUP = 5'h02;
   localparam [4:0] ST_STROBE = 5'h04;
   localparam [4:0] ST_HOLD = 5'h08;
   localparam [4:0] ST_TURN = 5'h10;

   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [`AMSS_CNT_W-1:0] cnt_q;
   reg [`AMSS_CNT_W-1:0] cnt_d;
   reg ready_d;
   reg write_q;
   reg ss_q;
   reg [CS_N-1:0] cs_sel_q;
   wire [`AMSS_CNT_W-1:0] start_len;
   wire [`AMSS_CNT_W-1:0] strobe_len;
   wire [`AMSS_CNT_W-1:0] hold_len;
   wire [`AMSS_CNT_W-1:0] turn_len;
   wire last;
   wire near_last;
   wire take;
   wire start;
   wire setup_end;
   wire strobe_end;
   wire hold_end;
   wire turn_end;
   wire [CS_N-1:0] cs_dec;

   // Settings give phase length minus one
   assign start_len = req_write ? {2'h0, write_setup_count} : {2'h0, read_setup_count};
   assign strobe_len = write_q ? write_strobe_count : read_strobe_count;
   assign hold_len = write_q ? {3'h0, write_hold_count} : {3'h0, read_hold_count};
   assign turn_len = {4'h0, turnaround_count};
   assign last = (cnt_q == 6'h00);
   assign near_last = (cnt_q == 6'h01);
   assign cs_dec = {{(CS_N-1){1'b0}}, 1'b1} << req_cs;
   assign take = req_valid && req_ready;
   assign setup_end = (state_q == ST_SETUP) && last;
   assign strobe_end = (state_q == ST_STROBE) && last;
   assign hold_end = (state_q == ST_HOLD) && last;
   assign turn_end = (state_q == ST_TURN) && last;
   // Take in idle or in the final turnaround cycle, so back to back
   // accesses see exactly the programmed turnaround
   assign start = take && ((state_q == ST_IDLE) || turn_end);

   // Phase sequencing
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               cnt_d = start_len;
               state_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (last) begin
               cnt_d = strobe_len;
               state_d = ST_STROBE;
            end else begin
               cnt_d = cnt_q - 6'h01;
            end
         end
         ST_STROBE: begin
            if (last) begin
               cnt_d = hold_len;
               state_d = ST_HOLD;
            end else begin
               cnt_d = cnt_q - 6'h01;
            end
         end
         ST_HOLD: begin
            // Address and data unchanged through hold
            if (last) begin
               cnt_d = turn_len;
               state_d = ST_TURN;
            end else begin
               cnt_d = cnt_q - 6'h01;
            end
         end
         ST_TURN: begin
            if (last) begin
               if (start) begin
                  cnt_d = start_len;
                  state_d = ST_SETUP;
               end else begin
                  state_d = ST_IDLE;
               end
            end else begin
               cnt_d = cnt_q - 6'h01;
            end
         end
         default: begin
            cnt_d = 6'h00;
            state_d = ST_IDLE;
         end
      endcase
   end

   // Ready stands through idle and the last turnaround cycle only
   always @* begin
      ready_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            ready_d = !take;
         end
         ST_HOLD: begin
            ready_d = last && (turn_len == 6'h00);
         end
         ST_TURN: begin
            if (last) begin
               ready_d = !take;
            end else begin
               ready_d = near_last;
            end
         end
         default: begin
            ready_d = 1'b0;
         end
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cnt_q <= 6'h00;
         req_ready <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         req_ready <= ready_d;
      end
   end

   // Access kind, mode and select latched at the take
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         write_q <= 1'b0;
         ss_q <= 1'b0;
         cs_sel_q <= {CS_N{1'b0}};
      end else begin
         if (start) begin
            write_q <= req_write;
            ss_q <= strobe_select_mode;
            cs_sel_q <= cs_dec;
         end
      end
   end

   // Select early with the address, or with the strobe in strobe-select mode
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_chip_select_n <= {CS_N{1'b1}};
      end else begin
         if (start) begin
            if (strobe_select_mode) begin
               mem_chip_select_n <= {CS_N{1'b1}};
            end else begin
               mem_chip_select_n <= ~cs_dec;
            end
         end else if (setup_end) begin
            mem_chip_select_n <= ~cs_sel_q;
         end else if (strobe_end && ss_q) begin
            mem_chip_select_n <= {CS_N{1'b1}};
         end else if (hold_end || (state_q == ST_IDLE)) begin
            mem_chip_select_n <= {CS_N{1'b1}};
         end
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_read_strobe_n <= 1'b1;
      end else begin
         if (setup_end && !write_q) begin
            mem_read_strobe_n <= 1'b0;
         end else if (strobe_end || (state_q == ST_IDLE)) begin
            mem_read_strobe_n <= 1'b1;
         end
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_write_strobe_n <= 1'b1;
      end else begin
         if (setup_end && write_q) begin
            mem_write_strobe_n <= 1'b0;
         end else if (strobe_end || (state_q == ST_IDLE)) begin
            mem_write_strobe_n <= 1'b1;
         end
      end
   end

   // Address and write data load only at the take
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_word_addr <= 22'h000000;
      end else begin
         if (start) begin
            mem_word_addr <= req_word_addr;
         end
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_byte_addr <= 2'h0;
      end else begin
         if (start) begin
            mem_byte_addr <= req_byte_addr;
         end
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_data_bus_out <= 16'h0000;
      end else begin
         if (start) begin
            mem_data_bus_out <= req_wdata;
         end
      end
   end

   // Bus driven from take to end of write hold
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_data_bus_oe <= 1'b0;
      end else begin
         if (start) begin
            mem_data_bus_oe <= req_write;
         end else if (hold_end || (state_q == ST_IDLE)) begin
            mem_data_bus_oe <= 1'b0;
         end
      end
   end

   // Read data taken at the edge that ends the strobe
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
         rd_data <= 16'h0000;
      end else begin
         rd_valid <= strobe_end && !write_q;
         if (strobe_end && !write_q) begin
            rd_data <= mem_data_bus_in;
         end
      end
   end
endmodule

// [tb/amss_seq_assertions.sv]
/* Timing checker for the strobe sequencer, bound to amss_seq.
 Assumes settings and mode stay stable from request to end of access. */
`timescale 1ns/1ps
module amss_seq_assertions #(parameter CS_N = 4) (
   input wire clock,
   input wire rst_n,
   input wire req_valid,
   input wire req_ready,
   input wire req_write,
   input wire [2:0] read_hold_count,
   input wire [2:0] write_hold_count,
   input wire [1:0] turnaround_count,
   input wire rd_valid,
   input wire strobe_select_mode,
   input wire [3:0] read_setup_count,
   input wire [5:0] read_strobe_count,
   input wire [3:0] write_setup_count,
   input wire [5:0] write_strobe_count,
   input wire [CS_N-1:0] mem_chip_select_n,
   input wire mem_read_strobe_n,
   input wire mem_write_strobe_n,
   input wire [21:0] mem_word_addr,
   input wire [1:0] mem_byte_addr,
   input wire mem_data_bus_oe
);
   reg [6:0] ol_q = 7'h00, wl_q = 7'h00, cl_q = 7'h00;
   reg [7:0] bz_q = 8'h00;
   reg armed_q = 1'b0;
   wire sel = !(&mem_chip_select_n);
   // Consecutive low cycles of each strobe and of the select
   always @(posedge clock) begin
      ol_q <= mem_read_strobe_n ? 7'h00 : ol_q + 7'h01;
      wl_q <= mem_write_strobe_n ? 7'h00 : wl_q + 7'h01;
      cl_q <= sel ? cl_q + 7'h01 : 7'h00;
      bz_q <= req_ready ? 8'h00 : bz_q + 8'h01;
      armed_q <= rst_n && (armed_q || (req_valid && req_ready));
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   rd_width_a: assert property ($rose(mem_read_strobe_n) |-> ol_q == read_strobe_count + 1)
      else $error("read strobe width wrong");
   wr_width_a: assert property ($rose(mem_write_strobe_n) |-> wl_q == write_strobe_count + 1
      && mem_data_bus_oe) else $error("write strobe width wrong");
   rd_lead_a: assert property ($fell(mem_read_strobe_n) && !strobe_select_mode
      |-> cl_q == read_setup_count + 1) else $error("read select lead wrong");
   wr_lead_a: assert property ($fell(mem_write_strobe_n) && !strobe_select_mode
      |-> cl_q == write_setup_count + 1) else $error("write select lead wrong");
   ss_follow_a: assert property (strobe_select_mode
      |-> !sel == (mem_read_strobe_n && mem_write_strobe_n)) else $error("select not on strobe");
   addr_hold_a: assert property ($past(sel) && sel
      |-> $stable({mem_word_addr, mem_byte_addr})) else $error("address moved in access");
   rd_capture_a: assert property ($rose(mem_read_strobe_n) |-> rd_valid)
      else $error("no read data at strobe end");
   idle_quiet_a: assert property (req_ready |-> !sel && mem_read_strobe_n
      && mem_write_strobe_n && !mem_data_bus_oe) else $error("pins active while idle");
   len_a: assert property ($rose(req_ready) && armed_q |-> bz_q == (req_write
      ? write_setup_count + write_strobe_count + write_hold_count
      : read_setup_count + read_strobe_count + read_hold_count) + turnaround_count + 8'h03)
      else $error("access length wrong");
endmodule
bind amss_seq amss_seq_assertions #(.CS_N(CS_N)) chk (.*);

// [tb/amss_mem_model.sv]
/* Asynchronous static memory on the sequencer's far side.
 Reads are combinational; writes land while the write strobe is low. */
`timescale 1ns/1ps
module amss_mem_model (
   input wire clock,
   input wire [3:0] mem_chip_select_n,
   input wire mem_read_strobe_n,
   input wire mem_write_strobe_n,
   input wire [21:0] mem_word_addr,
   input wire [1:0] mem_byte_addr,
   input wire [15:0] mem_data_bus_in,
   output wire [15:0] mem_rdata
);
   reg [15:0] ram [0:15];
   reg [23:0] tag [0:15];
   reg [15:0] last_q = 16'h0000;
   wire on = mem_chip_select_n != 4'hf;
   wire [3:0] slot = {mem_word_addr[1:0], mem_byte_addr};
   wire hit = tag[slot] === {mem_word_addr, mem_byte_addr};
   // Released bus or wrong address shows the inverse of the last word
   assign mem_rdata = (on && !mem_read_strobe_n && hit) ? ram[slot] : ~last_q;
   always @(posedge clock) begin
      if (on && !mem_read_strobe_n)
         last_q <= mem_rdata;
      if (on && !mem_write_strobe_n) begin
         ram[slot] <= mem_data_bus_in;
         tag[slot] <= {mem_word_addr, mem_byte_addr};
      end
   end
endmodule

// [tb/test_async_memory_strobe_sequencer.sv]
/* Bench: random writes then read-back with random settings and modes.
 Needs amss_mem_model and the bound checker. */
`timescale 1ns/1ps
module test_async_memory_strobe_sequencer;
   reg clock = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0, strobe_select_mode = 1'h0;
   reg [1:0] req_cs = 2'h0, req_byte_addr = 2'h0, turnaround_count = 2'h0;
   reg [21:0] req_word_addr = 22'h0;
   reg [15:0] req_wdata = 16'h0;
   reg [3:0] read_setup_count = 4'h0, write_setup_count = 4'h0;
   reg [5:0] read_strobe_count = 6'h0, write_strobe_count = 6'h0;
   reg [2:0] read_hold_count = 3'h0, write_hold_count = 3'h0;
   wire req_ready, rd_valid, mem_read_strobe_n, mem_write_strobe_n, mem_data_bus_oe;
   wire [3:0] mem_chip_select_n;
   wire [21:0] mem_word_addr;
   wire [1:0] mem_byte_addr;
   wire [15:0] rd_data, mem_data_bus_out, mem_rdata;
   wire [15:0] mem_data_bus_in = mem_data_bus_oe ? mem_data_bus_out : mem_rdata;
   int mismatches = 0, samples_checked = 0, i, n;
   logic [15:0] expq[$], dat[16];
   logic [23:0] adr[16];
   amss_seq DUT (.*);
   amss_mem_model mem (.*);
   initial forever #2 clock = ~clock;
   task chk(input [15:0] e, input [15:0] g);
      samples_checked++;
      if (e !== g) begin
         mismatches++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task end_sim;
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task acc(input w, input [23:0] a, input [15:0] d);
      for (n = 0; n < 300 && req_ready !== 1'b1; n++) @(negedge clock);
      if (n >= 300) begin
         mismatches++;
         end_sim;
      end
      @(posedge clock);
      {req_valid, req_write, req_word_addr, req_byte_addr, req_wdata} <= {1'b1, w, a, d};
      {req_cs, strobe_select_mode} <= 3'($urandom);
      {read_setup_count, read_strobe_count, read_hold_count, write_setup_count,
         write_strobe_count, write_hold_count, turnaround_count} <= 28'($urandom);
      if (!w) expq.push_back(d);
      @(posedge clock);
      req_valid <= 1'b0;
      @(negedge clock);
   endtask
   always @(negedge clock) if (rd_valid === 1'b1) chk(expq.pop_front(), rd_data);
   initial begin
      n = $urandom(69781);
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      for (i = 0; i < 32; i++) begin
         if (i < 16) begin
            adr[i] = {20'($urandom), i[3:0]};
            dat[i] = 16'($urandom);
            acc(1'b1, adr[i], dat[i]);
         end else acc(1'b0, adr[31 - i], dat[31 - i]);
      end
      for (n = 0; n < 300 && expq.size() > 0; n++) @(posedge clock);
      if (n >= 300) mismatches++;
      end_sim;
   end
endmodule
